// >>> verification/snvm_host.sv
// Purpose: Host serial master model that drives the memory pins
// Assumes: Serial clock idles low and runs at 80 ns only inside frames
// Notes: Pins change on the falling system clock edge; bytes the device drives raise got
`timescale 1ns/100ps
`default_nettype none
module snvm_host (
    // Clock
    input wire logic sys_clk,
    // Pins toward the device
    output var snvm_pkg::snvm_pins_t pins,
    // Serial output of the device
    input wire logic miso_out,
    input wire logic miso_oe
);
    import snvm_pkg::*;
    // ============================================================
    // Captured output byte
    logic [7:0] rx_byte;
    event got;

    initial begin
        pins = '{cs_n: 1'b0, sck: 1'b0, mosi: 1'b0, hold_n: 1'b1, write_protect_pin: 1'b1};
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // ============================================================
    // Framing, select moves only with the clock low
    task automatic cs(input logic v);
        tick(8);
        pins.cs_n = v;
        if (v) pins.mosi = ~pins.mosi;
        tick(8);
    endtask

    task automatic pin(input logic h, input logic w);
        tick(8);
        pins.hold_n = h;
        pins.write_protect_pin = w;
        tick(12);
    endtask

    // ============================================================
    // One byte each way, sample at the rising clock
    task automatic xfer(input logic [7:0] tx);
        int n;
        n = 0;
        for (int i = 7; i >= 0; i--) begin
            pins.mosi = tx[i];
            tick(8);
            pins.sck = 1'b1;
            rx_byte[i] = miso_oe ? miso_out : ~miso_out;
            n += int'(miso_oe === 1'b1);
            tick(8);
            pins.sck = 1'b0;
        end
        if (n == 8) -> got;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the serial memory command block
// Assumes: Host model drives all pins; program cycle shortened to PROG
// Notes: Bytes the device drives are compared against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module tb;
    import snvm_pkg::*;
    localparam int PROG = 600;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    snvm_pins_t pins;
    wire logic miso_out;
    wire logic miso_oe;
    wire logic busy;
    wire logic [7:0] status_view;
    logic [7:0] mem [0:SNVM_DEPTH-1];
    logic [7:0] exp_q [$];
    logic wp = 1'b1;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;

    always #2.5 sys_clk = ~sys_clk;

    snvm_cmd #(.PROG_CYCLES(PROG)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins),
        .miso_out(miso_out), .miso_oe(miso_oe), .busy(busy), .status_view(status_view));
    snvm_host i_host (.sys_clk(sys_clk), .pins(pins), .miso_out(miso_out), .miso_oe(miso_oe));

    // ============================================================
    // Reporting
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(i_host.got) begin
        check("miso byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, i_host.rx_byte);
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ============================================================
    // Command sequences
    task automatic cmd(input logic [7:0] op);
        i_host.cs(1'b0);
        i_host.xfer(op);
        i_host.cs(1'b1);
    endtask

    task automatic sr_read(input logic [7:0] e);
        i_host.cs(1'b0);
        i_host.xfer(SNVM_OP_STATUS_READ);
        exp_q.push_back(e);
        i_host.xfer(8'($urandom));
        i_host.cs(1'b1);
    endtask

    // Busy must match acceptance; a status read is squeezed into the cycle
    task automatic settle(input logic ok);
        check("busy", {7'h0, ok}, {7'h0, busy});
        if (ok) sr_read(8'hff);
        for (int i = 0; i < PROG + 50 && busy !== 1'b0; i++) i_host.tick(1);
        check("busy end", 8'h00, {7'h0, busy});
        if (ok) check("latch after cycle", 8'h00, status_view & 8'h03);
    endtask

    task automatic sr_write(input logic [7:0] v, input logic ok);
        cmd(SNVM_OP_LATCH_SET);
        i_host.cs(1'b0);
        i_host.xfer(SNVM_OP_STATUS_WRITE);
        i_host.xfer(v);
        i_host.cs(1'b1);
        settle(ok);
    endtask

    // Mode 0 no latch, 1 latch in its own frame, 2 latch in the same frame
    task automatic prog(input logic [12:0] a, input int n, input logic ok, input int mode);
        logic [7:0] d;
        if (mode == 1) cmd(SNVM_OP_LATCH_SET);
        i_host.cs(1'b0);
        if (mode == 2) i_host.xfer(SNVM_OP_LATCH_SET);
        i_host.xfer(SNVM_OP_PROGRAM);
        i_host.xfer({3'h0, a[12:8]});
        i_host.xfer(a[7:0]);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (ok) mem[a + 13'(i)] = d;
            i_host.xfer(d);
        end
        i_host.cs(1'b1);
        settle(ok);
    endtask

    task automatic rd(input logic [12:0] a, input int n);
        i_host.cs(1'b0);
        i_host.xfer(SNVM_OP_READ);
        i_host.xfer({3'h0, a[12:8]});
        i_host.xfer(a[7:0]);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[a + 13'(i)]);
            if (i == 2) begin
                i_host.pin(1'b0, wp);
                check("oe in hold", 8'h00, {7'h0, miso_oe});
                i_host.xfer(8'h5a);
                i_host.pin(1'b1, wp);
            end
            i_host.xfer(8'($urandom));
        end
        i_host.cs(1'b1);
        check("oe after select", 8'h00, {7'h0, miso_oe});
    endtask

    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(32'hab757e8a));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        check("idle oe", 8'h00, {7'h0, miso_oe});
        check("reset status", 8'h00, status_view);
        check("reset busy", 8'h00, {7'h0, busy});
        i_host.xfer(SNVM_OP_LATCH_SET);
        check("no select edge", 8'h00, status_view);
        i_host.cs(1'b1);
        cmd(SNVM_OP_LATCH_SET);
        check("latch set", 8'h02, status_view);
        sr_read(8'h02);
        cmd(SNVM_OP_LATCH_CLEAR);
        check("latch clear", 8'h00, status_view);
        prog(13'h0100, 32, 1'b0, 0);
        prog(13'h0020, 31, 1'b0, 1);
        cmd(SNVM_OP_LATCH_CLEAR);
        prog(13'h0040, 32, 1'b0, 2);
        prog(13'h1fe0, 32, 1'b1, 1);
        prog(13'h0000, 32, 1'b1, 1);
        for (int c = 1; c < 4; c++) begin
            sr_write(8'(c << 2), 1'b1);
            prog(13'h1fe0, 32, 1'b0, 1);
            prog(13'h1000, 32, c == 1, 1);
            prog(13'h0000, 32, c < 3, 1);
        end
        sr_write(8'h8c, 1'b1);
        check("status kept", 8'h8c, status_view);
        wp = 1'b0;
        i_host.pin(1'b1, wp);
        sr_write(8'h00, 1'b0);
        check("protected status", 8'h8c, status_view & 8'h8c);
        wp = 1'b1;
        i_host.pin(1'b1, wp);
        sr_write(8'h00, 1'b1);
        check("status cleared", 8'h00, status_view);
        rd(13'h1ffe, 4);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> verilog/snvm_cmd.sv
// Purpose: Serial command decoder, array and status programming for a small nonvolatile memory
// Assumes: Host drives chip select, serial clock, serial input, hold and protect pins
// Notes: Array kept in flip-flops; program cycle is a timed busy window
`timescale 1ns/100ps
`default_nettype none
module snvm_cmd
    import snvm_pkg::*;
#(
    parameter int PROG_CYCLES = SNVM_PROG_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial pins
    input wire snvm_pkg::snvm_pins_t pins,
    output logic miso_out,
    output logic miso_oe,
    // Status view
    output logic busy,
    output logic [7:0] status_view
);
    import snvm_pkg::*;

    // ============================================================
    // Pin synchronisers
    logic cs_n_s, sck_s, mosi_s, hold_n_s, wp_s;
    snvm_sync u_cs (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins.cs_n), .level_out(cs_n_s));
    snvm_sync u_sck (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins.sck), .level_out(sck_s));
    snvm_sync u_mosi (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins.mosi), .level_out(mosi_s));
    snvm_sync u_hold (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins.hold_n), .level_out(hold_n_s));
    snvm_sync u_wp (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins.write_protect_pin), .level_out(wp_s));

    // ============================================================
    // Edge detection
    logic sck_d_reg, cs_d_reg, hold_reg, hold_next, warm_done;
    logic [2:0] warm_reg, warm_next;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    assign warm_done = (warm_reg == 3'(SNVM_SYNC_STAGES + 2)); // Stages hold reset levels until then
    assign sck_rise = warm_done && sck_s && !sck_d_reg && !hold_reg;
    assign sck_fall = warm_done && !sck_s && sck_d_reg && !hold_reg;
    assign cs_fall = warm_done && !cs_n_s && cs_d_reg;
    assign cs_rise = warm_done && cs_n_s && !cs_d_reg;

    always_comb begin
        hold_next = hold_reg;
        warm_next = warm_done ? warm_reg : warm_reg + 3'd1;
        if (!sck_s) begin
            hold_next = !hold_n_s;
        end
    end

    // ============================================================
    // Storage
    logic [7:0] mem [SNVM_DEPTH];
    logic [7:0] page_reg [SNVM_SECTOR_BYTES];

    // ============================================================
    // Control state
    snvm_state_t st_reg, st_next;
    logic [7:0] op_reg, op_next, sh_reg, sh_next, out_reg, out_next;
    logic [2:0] bit_reg, bit_next;
    logic [3:0] abit_reg, abit_next;
    logic [15:0] addr_reg, addr_next;
    logic [5:0] cnt_reg, cnt_next;
    logic armed_reg, armed_next, latch_cmd_reg, latch_cmd_next;
    logic wel_reg, wel_next, oe_reg, oe_next, drv_reg, drv_next;
    logic [7:0] sr_reg, sr_next, sr_data_reg, sr_data_next;
    logic [31:0] prog_cnt_reg, prog_cnt_next;
    logic prog_arr_reg, prog_arr_next, prog_sr_reg, prog_sr_next;
    logic byte_done, hw_protect, sector_locked, start_arr, start_sr;
    logic [7:0] sh_in, status_byte;

    assign hw_protect = !wp_s && sr_reg[SNVM_SR_PROT_EN];
    assign busy = prog_arr_reg || prog_sr_reg;
    assign sh_in = {sh_reg[6:0], mosi_s};
    assign byte_done = sck_rise && (bit_reg == 3'd7);

    assign status_byte = busy ? SNVM_SR_BUSY : {sr_reg[7:2], wel_reg, 1'b0};
    assign status_view = status_byte;

    always_comb begin
        case (sr_reg[SNVM_SR_LOCK_HI:SNVM_SR_LOCK_LO])
            2'b01: sector_locked = (addr_reg[12:11] == 2'b11);
            2'b10: sector_locked = addr_reg[12];
            2'b11: sector_locked = 1'b1;
            default: sector_locked = 1'b0;
        endcase
    end

    // Start conditions on chip select rise
    assign start_arr = cs_rise && (st_reg == SNVM_ST_DATA_IN) && (op_reg == SNVM_OP_PROGRAM) &&
        (cnt_reg == SNVM_SECTOR_LAST) && (bit_reg == 3'd0) && wel_reg && !sector_locked;
    assign start_sr = cs_rise && (st_reg == SNVM_ST_DATA_IN) && (op_reg == SNVM_OP_STATUS_WRITE) &&
        (cnt_reg == 6'd1) && (bit_reg == 3'd0) && wel_reg && !hw_protect;

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        sh_next = sh_reg;
        out_next = out_reg;
        bit_next = bit_reg;
        abit_next = abit_reg;
        addr_next = addr_reg;
        cnt_next = cnt_reg;
        armed_next = armed_reg;
        latch_cmd_next = latch_cmd_reg;
        wel_next = wel_reg;
        oe_next = oe_reg;
        drv_next = drv_reg;
        sr_next = sr_reg;
        sr_data_next = sr_data_reg;
        prog_cnt_next = prog_cnt_reg;
        prog_arr_next = prog_arr_reg;
        prog_sr_next = prog_sr_reg;
        if (sck_rise) begin
            sh_next = sh_in;
            bit_next = bit_reg + 3'd1;
        end
        if (cs_fall) begin
            armed_next = 1'b1;
            st_next = SNVM_ST_OPCODE;
            bit_next = 3'd0;
            latch_cmd_next = 1'b0;
            cnt_next = 6'd0;
        end else if (cs_n_s) begin
            st_next = SNVM_ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                SNVM_ST_OPCODE: begin
                    if (byte_done && armed_reg) begin
                        op_next = sh_in;
                        abit_next = 4'd0;
                        st_next = SNVM_ST_IGNORE;
                        if (sh_in == SNVM_OP_STATUS_READ) begin
                            st_next = SNVM_ST_DATA_OUT;
                            out_next = status_byte;
                            drv_next = 1'b1;
                        end else if (busy) begin
                            st_next = SNVM_ST_IGNORE;
                        end else if (sh_in == SNVM_OP_LATCH_SET) begin
                            wel_next = 1'b1;
                            latch_cmd_next = 1'b1;
                        end else if (sh_in == SNVM_OP_LATCH_CLEAR) begin
                            wel_next = 1'b0;
                        end else if (sh_in == SNVM_OP_READ || sh_in == SNVM_OP_PROGRAM) begin
                            st_next = SNVM_ST_ADDR;
                        end else if (sh_in == SNVM_OP_STATUS_WRITE) begin
                            st_next = SNVM_ST_DATA_IN;
                        end
                    end
                end
                SNVM_ST_ADDR: begin
                    if (sck_rise) begin
                        addr_next = {addr_reg[14:0], mosi_s};
                        abit_next = abit_reg + 4'd1;
                        if (abit_reg == 4'd15) begin
                            if (op_reg == SNVM_OP_READ) begin
                                st_next = SNVM_ST_DATA_OUT;
                                out_next = mem[{addr_reg[SNVM_ADDR_W-2:0], mosi_s}];
                                drv_next = 1'b1;
                            end else begin
                                st_next = SNVM_ST_DATA_IN;
                            end
                        end
                    end
                end
                SNVM_ST_DATA_IN: begin
                    if (byte_done) begin
                        cnt_next = cnt_reg + 6'd1;
                        if (op_reg == SNVM_OP_STATUS_WRITE && cnt_reg == 6'd0) begin
                            sr_data_next = sh_in;
                        end
                    end
                end
                SNVM_ST_DATA_OUT: begin
                    if (sck_fall) begin
                        oe_next = 1'b1;
                        if (drv_reg) begin
                            drv_next = 1'b0;
                        end else begin
                            out_next = {out_reg[6:0], 1'b0};
                        end
                    end
                    if (byte_done) begin
                        drv_next = 1'b1;
                        if (op_reg == SNVM_OP_READ) begin
                            addr_next = addr_reg + 16'd1;
                            if (addr_reg[SNVM_ADDR_W-1:0] == {SNVM_ADDR_W{1'b1}}) begin
                                addr_next = 16'h0000;
                            end
                            out_next = mem[addr_next[SNVM_ADDR_W-1:0]];
                        end else begin
                            out_next = status_byte;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (start_arr) begin
            prog_arr_next = 1'b1;
            prog_cnt_next = 32'd0;
        end
        if (start_sr) begin
            prog_sr_next = 1'b1;
            prog_cnt_next = 32'd0;
            sr_next = sr_data_reg & SNVM_SR_KEEP_MASK;
        end
        if (busy) begin
            prog_cnt_next = prog_cnt_reg + 32'd1;
            if (prog_cnt_reg == PROG_CYCLES - 1) begin
                prog_arr_next = 1'b0;
                prog_sr_next = 1'b0;
                wel_next = 1'b0;
            end
        end
    end

    // Array writes from the sector buffer happen at the cycle start
    always_ff @(posedge sys_clk) begin
        if (!cs_n_s && st_reg == SNVM_ST_DATA_IN && op_reg == SNVM_OP_PROGRAM && byte_done &&
            cnt_reg < SNVM_SECTOR_LAST) begin
            page_reg[cnt_reg[4:0]] <= sh_in;
        end
        if (start_arr) begin
            for (int i = 0; i < SNVM_SECTOR_BYTES; i++) begin
                mem[{addr_reg[SNVM_ADDR_W-1:5], 5'(i)}] <= page_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= SNVM_ST_IDLE;
            op_reg <= 8'h00;
            sh_reg <= 8'h00;
            out_reg <= 8'h00;
            bit_reg <= 3'd0;
            abit_reg <= 4'd0;
            addr_reg <= 16'h0000;
            cnt_reg <= 6'd0;
            armed_reg <= 1'b0;
            latch_cmd_reg <= 1'b0;
            wel_reg <= 1'b0;
            oe_reg <= 1'b0;
            drv_reg <= 1'b0;
            sr_reg <= SNVM_SR_RESET;
            sr_data_reg <= 8'h00;
            prog_cnt_reg <= 32'd0;
            prog_arr_reg <= 1'b0;
            prog_sr_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            hold_reg <= 1'b0;
            warm_reg <= 3'd0;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            sh_reg <= sh_next;
            out_reg <= out_next;
            bit_reg <= bit_next;
            abit_reg <= abit_next;
            addr_reg <= addr_next;
            cnt_reg <= cnt_next;
            armed_reg <= armed_next;
            latch_cmd_reg <= latch_cmd_next;
            wel_reg <= wel_next;
            oe_reg <= oe_next;
            drv_reg <= drv_next;
            sr_reg <= sr_next;
            sr_data_reg <= sr_data_next;
            prog_cnt_reg <= prog_cnt_next;
            prog_arr_reg <= prog_arr_next;
            prog_sr_reg <= prog_sr_next;
            sck_d_reg <= sck_s;
            cs_d_reg <= cs_n_s;
            hold_reg <= hold_next;
            warm_reg <= warm_next;
        end
    end

    assign miso_out = out_reg[7];
    assign miso_oe = oe_reg && !hold_reg;

    // ============================================================
    // Checks
    a_oe_off_deselect: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cs_n_s |=> !miso_oe) else $error("output driven while deselected");
    a_latch_set_op: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == SNVM_ST_OPCODE && byte_done && armed_reg && !busy && !latch_cmd_reg &&
         sh_in == SNVM_OP_LATCH_SET && !cs_fall && !cs_n_s) |=> wel_reg) else $error("latch not set");
    a_latch_clr_op: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == SNVM_ST_OPCODE && byte_done && armed_reg && !busy && !latch_cmd_reg &&
         sh_in == SNVM_OP_LATCH_CLEAR && !cs_fall && !cs_n_s) |=> !wel_reg) else $error("latch not cleared");
    a_busy_all_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy |-> status_view == 8'hff) else $error("busy status not all ones");
    a_prot_status: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hw_protect && !busy |=> $stable(sr_reg)) else $error("status changed under protection");
    a_need_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !wel_reg && !busy |=> !busy) else $error("cycle started without latch");
    a_latch_auto_clr: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) |-> !wel_reg) else $error("latch kept after cycle");
    a_no_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy |=> (prog_cnt_reg != 32'd0) || !busy) else $error("cycle restarted while busy");
    a_wrap_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_reg == SNVM_ST_DATA_OUT && op_reg == SNVM_OP_READ && byte_done && !cs_n_s && !cs_fall &&
         addr_reg[12:0] == 13'h1fff) |=> addr_reg == 16'h0000) else $error("address did not wrap");
    a_all_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sr_reg[3:2] == 2'b11 |-> !start_arr) else $error("locked array programmed");
endmodule
`default_nettype wire

// >>> verilog/snvm_pkg.sv
// Purpose: Shared constants and types for the serial nonvolatile memory command block
// Assumes: Single system clock at 200 MHz; serial pins are asynchronous to it
// Notes: Array is 8 KiB organised as bytes in 32-byte sectors
package snvm_pkg;
    // ============================================================
    // Opcodes
    localparam logic [7:0] SNVM_OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] SNVM_OP_PROGRAM = 8'h02;
    localparam logic [7:0] SNVM_OP_READ = 8'h03;
    localparam logic [7:0] SNVM_OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] SNVM_OP_STATUS_READ = 8'h05;
    localparam logic [7:0] SNVM_OP_LATCH_SET = 8'h06;
    // ============================================================
    // Array geometry
    localparam int SNVM_ADDR_W = 13;
    localparam int SNVM_DEPTH = 8192;
    localparam int SNVM_SECTOR_BYTES = 32;
    localparam logic [5:0] SNVM_SECTOR_LAST = 6'h20;
    // ============================================================
    // Status bit positions
    localparam int SNVM_SR_PROT_EN = 7;
    localparam int SNVM_SR_LOCK_HI = 3;
    localparam int SNVM_SR_LOCK_LO = 2;
    localparam int SNVM_SR_WEL = 1;
    localparam int SNVM_SR_WIP = 0;
    localparam logic [7:0] SNVM_SR_KEEP_MASK = 8'h8c;
    localparam logic [7:0] SNVM_SR_RESET = 8'h00;
    localparam logic [7:0] SNVM_SR_BUSY = 8'hff;
    // ============================================================
    // Timing
    localparam int SNVM_CLK_PERIOD_NS = 5;
    localparam int SNVM_PROG_TIME_US = 10000;
    localparam int SNVM_PROG_CYCLES = SNVM_PROG_TIME_US * 1000 / SNVM_CLK_PERIOD_NS;
    localparam int SNVM_SYNC_STAGES = 3;
    // ============================================================
    // Types
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
        logic hold_n;
        logic write_protect_pin;
    } snvm_pins_t;

    typedef enum logic [5:0] {
        SNVM_ST_IDLE = 6'b000001,
        SNVM_ST_OPCODE = 6'b000010,
        SNVM_ST_ADDR = 6'b000100,
        SNVM_ST_DATA_IN = 6'b001000,
        SNVM_ST_DATA_OUT = 6'b010000,
        SNVM_ST_IGNORE = 6'b100000
    } snvm_state_t;
endpackage

// >>> verilog/snvm_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Input is asynchronous to sys_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module snvm_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

    always_comb begin
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            lvl_reg <= 1'b1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule
`default_nettype wire
